// ==== logic/aspc_pkg.sv ====
/*
  Package for the audio signal path control block: register indices, field positions,
  reset values and the output carrier types.
  Assumes a 32-bit Avalon-MM slave where each register takes one aligned word.
*/
`default_nettype none
package aspc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] ASPC_IDX_LINE_OUT = 4'h2;
  localparam logic [3:0] ASPC_IDX_SPK_GAIN = 4'h3;
  localparam logic [3:0] ASPC_IDX_MIXER = 4'h7;
  localparam logic [3:0] ASPC_IDX_SPK_CFG2 = 4'ha;
  localparam logic [3:0] ASPC_IDX_POWER = 4'hb;
  localparam logic [3:0] ASPC_IDX_TIMEOUT = 4'hc;
  localparam logic [3:0] ASPC_IDX_STATUS = 4'hd;

  // Mixer register fields.
  localparam int ASPC_MIX_IN_A_EN = 0;
  localparam int ASPC_MIX_IN_A_ATT = 1;
  localparam int ASPC_MIX_IN_B_EN = 2;
  localparam int ASPC_MIX_IN_B_ATT = 3;
  localparam int ASPC_MIX_CONV_SEL = 4;
  // Level register fields (line output and speaker gain stage).
  localparam int ASPC_LVL_MUTE = 7;
  localparam int ASPC_LVL_ZC = 6;
  localparam int ASPC_LVL_VOL_MSB = 5;
  // Power register fields.
  localparam int ASPC_PWR_LINE_OUT = 4;
  localparam int ASPC_PWR_SPK_GAIN = 2;
  localparam int ASPC_PWR_SPK_DRV = 1;
  // Second speaker register fields.
  localparam int ASPC_SPK_CLASS = 6;
  localparam int ASPC_SPK_GUARD_A = 4;
  localparam int ASPC_SPK_GUARD_B = 3;
  // Timeout register fields.
  localparam int ASPC_TO_ENABLE = 8;
  localparam int ASPC_TO_DIV_MSB = 7;

  // Reset values.
  localparam logic [5:0] ASPC_VOL_RESET = 6'h39;
  localparam logic ASPC_MUTE_RESET = 1'b1;
  localparam logic ASPC_GUARD_RESET = 1'b1;
  localparam logic [7:0] ASPC_TO_DIV_RESET = 8'h0f;

  // Cycles from the speaker driver write to the first pop guard change, and from there to the second.
  localparam int ASPC_GUARD_STEP_NS = 1000;
  localparam int ASPC_CLK_PERIOD_PS = 5000;
  localparam int ASPC_GUARD_STEP_CYC = (ASPC_GUARD_STEP_NS * 1000) / ASPC_CLK_PERIOD_PS;

  typedef enum logic {
    ASPC_CLASS_D,
    ASPC_CLASS_AB
  } aspc_class_t;

  typedef struct packed {
    logic in_a_enable;
    logic in_a_atten;
    logic in_b_enable;
    logic in_b_atten;
    logic conv_enable;
  } aspc_mixer_t;

  typedef struct packed {
    logic enable;
    logic mute;
    logic [5:0] volume;
  } aspc_level_t;

  typedef struct packed {
    logic gain_stage_enable;
    logic driver_enable;
    logic class_ab;
    logic pop_guard_a;
    logic pop_guard_b;
  } aspc_speaker_t;
endpackage
`default_nettype wire

// ==== logic/aspc_top.sv ====
/*
  Audio signal path control: mixer source selection, output stage enables, mute applied at once,
  and volume with zero-cross deferred update and timeout, and automatic Class D pop guard sequencing.
  Assumes an Avalon-MM master on clock_i and zero-cross detect pulses from the analogue side.
*/
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module aspc_top #(
  parameter int GUARD_STEP = aspc_pkg::ASPC_GUARD_STEP_CYC
) (
  input wire logic clock_i, // System clock, 200 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable; all state holds while low.
  input wire logic [5:0] avs_address_i, // Word address.
  input wire logic avs_read_i, // Read request.
  input wire logic avs_write_i, // Write request.
  input wire logic [31:0] avs_writedata_i, // Write data.
  input wire logic [3:0] avs_byteenable_i, // Byte enables.
  output logic [31:0] avs_readdata_o, // Read data.
  output logic avs_waitrequest_o, // Stall until the access is taken.
  input wire logic line_zero_cross_i, // Line output zero-cross pulse.
  input wire logic spk_zero_cross_i, // Speaker zero-cross pulse.
  output aspc_pkg::aspc_mixer_t mixer_o, // Mixer source controls.
  output aspc_pkg::aspc_level_t line_out_o, // Line output controls.
  output aspc_pkg::aspc_level_t spk_gain_o, // Speaker gain stage controls.
  output aspc_pkg::aspc_speaker_t speaker_o // Speaker driver controls.
);
  import aspc_pkg::*;

  initial begin
    if (GUARD_STEP < 1 || GUARD_STEP > 65535) begin
      $error("GUARD_STEP out of range");
    end
  end

  logic ack_r;
  logic acc;
  logic wr;
  logic [3:0] idx;
  logic hit;
  logic [4:0] mixer_r;
  logic [7:0] line_reg_r;
  logic [7:0] spk_reg_r;
  logic [5:0] line_vol_r;
  logic [5:0] spk_vol_r;
  logic line_pend_r;
  logic spk_pend_r;
  logic [2:0] power_r;
  logic class_ab_r;
  logic guard_a_r;
  logic guard_b_r;
  logic to_en_r;
  logic [7:0] to_div_r;
  logic [7:0] to_cnt_r;
  logic to_tick;
  logic [15:0] seq_cnt_r;
  logic [1:0] seq_stage_r;
  logic seq_target_r;
  logic [31:0] rd_nxt;
  logic wr_lvl_line;
  logic wr_lvl_spk;
  logic wr_spk_drv;

  // A request is taken on the second cycle so waitrequest is low for exactly one edge.
  assign acc = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr = avs_write_i & ack_r & ce_i & avs_byteenable_i[0];
  assign idx = avs_address_i[3:0];
  assign hit = (avs_address_i[5:4] == 2'b00);
  assign wr_lvl_line = wr & hit & (idx == ASPC_IDX_LINE_OUT);
  assign wr_lvl_spk = wr & hit & (idx == ASPC_IDX_SPK_GAIN);
  assign wr_spk_drv = wr & hit & (idx == ASPC_IDX_POWER);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= acc;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit) begin
      case (idx)
        ASPC_IDX_LINE_OUT: rd_nxt[7:0] = line_reg_r;
        ASPC_IDX_SPK_GAIN: rd_nxt[7:0] = spk_reg_r;
        ASPC_IDX_MIXER: rd_nxt[4:0] = mixer_r;
        ASPC_IDX_SPK_CFG2: begin
          rd_nxt[ASPC_SPK_CLASS] = class_ab_r;
          rd_nxt[ASPC_SPK_GUARD_A] = guard_a_r;
          rd_nxt[ASPC_SPK_GUARD_B] = guard_b_r;
        end
        ASPC_IDX_POWER: begin
          rd_nxt[ASPC_PWR_LINE_OUT] = power_r[2];
          rd_nxt[ASPC_PWR_SPK_GAIN] = power_r[1];
          rd_nxt[ASPC_PWR_SPK_DRV] = power_r[0];
        end
        ASPC_IDX_TIMEOUT: rd_nxt[8:0] = {to_en_r, to_div_r};
        ASPC_IDX_STATUS: begin
          rd_nxt[5:0] = line_vol_r;
          rd_nxt[13:8] = spk_vol_r;
          rd_nxt[16] = line_pend_r;
          rd_nxt[17] = spk_pend_r;
          rd_nxt[18] = (seq_stage_r != 2'd0);
        end
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && acc && avs_read_i) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mixer_r <= 5'h00;
    end else if (wr && hit && idx == ASPC_IDX_MIXER) begin
      mixer_r <= avs_writedata_i[4:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      power_r <= 3'b000;
    end else if (wr_spk_drv) begin
      power_r <= {avs_writedata_i[ASPC_PWR_LINE_OUT], avs_writedata_i[ASPC_PWR_SPK_GAIN],
                  avs_writedata_i[ASPC_PWR_SPK_DRV]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      to_en_r <= 1'b0;
      to_div_r <= ASPC_TO_DIV_RESET;
    end else if (wr && hit && idx == ASPC_IDX_TIMEOUT) begin
      to_en_r <= avs_writedata_i[ASPC_TO_ENABLE];
      to_div_r <= avs_writedata_i[ASPC_TO_DIV_MSB:0];
    end
  end

  // Timeout tick: one pulse every to_div_r + 1 cycles while enabled.
  assign to_tick = to_en_r & (to_cnt_r == to_div_r);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      to_cnt_r <= 8'h00;
    end else if (ce_i) begin
      if (!to_en_r || to_tick) begin
        to_cnt_r <= 8'h00;
      end else begin
        to_cnt_r <= to_cnt_r + 8'h01;
      end
    end
  end

  // Stored level registers; a write here is what software reads back.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      line_reg_r <= {ASPC_MUTE_RESET, 1'b0, ASPC_VOL_RESET};
    end else if (wr_lvl_line) begin
      line_reg_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      spk_reg_r <= {ASPC_MUTE_RESET, 1'b0, ASPC_VOL_RESET};
    end else if (wr_lvl_spk) begin
      spk_reg_r <= avs_writedata_i[7:0];
    end
  end

  // Applied line volume: at once, or held pending until a crossing or timeout.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      line_vol_r <= ASPC_VOL_RESET;
      line_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_lvl_line) begin
        if (!avs_writedata_i[ASPC_LVL_ZC]) begin
          line_vol_r <= avs_writedata_i[ASPC_LVL_VOL_MSB:0];
          line_pend_r <= 1'b0;
        end else begin
          line_pend_r <= 1'b1;
        end
      end else if (line_pend_r && (line_zero_cross_i || to_tick)) begin
        line_vol_r <= line_reg_r[ASPC_LVL_VOL_MSB:0];
        line_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      spk_vol_r <= ASPC_VOL_RESET;
      spk_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_lvl_spk) begin
        if (!avs_writedata_i[ASPC_LVL_ZC]) begin
          spk_vol_r <= avs_writedata_i[ASPC_LVL_VOL_MSB:0];
          spk_pend_r <= 1'b0;
        end else begin
          spk_pend_r <= 1'b1;
        end
      end else if (spk_pend_r && (spk_zero_cross_i || to_tick)) begin
        spk_vol_r <= spk_reg_r[ASPC_LVL_VOL_MSB:0];
        spk_pend_r <= 1'b0;
      end
    end
  end

  // Class D guard sequence: a driver enable write steps the guards toward the new state,
  // one guard per step, releasing guard A then B on enable and raising B then A on disable.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seq_stage_r <= 2'd0;
      seq_cnt_r <= 16'h0000;
      seq_target_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_spk_drv && class_ab_r == ASPC_CLASS_D) begin
        seq_stage_r <= 2'd1;
        seq_cnt_r <= 16'(GUARD_STEP - 1);
        seq_target_r <= avs_writedata_i[ASPC_PWR_SPK_DRV];
      end else if (seq_stage_r != 2'd0) begin
        if (seq_cnt_r != 16'h0000) begin
          seq_cnt_r <= seq_cnt_r - 16'h0001;
        end else if (seq_stage_r == 2'd1) begin
          seq_stage_r <= 2'd2;
          seq_cnt_r <= 16'(GUARD_STEP - 1);
        end else begin
          seq_stage_r <= 2'd0;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      class_ab_r <= 1'b0;
    end else if (wr && hit && idx == ASPC_IDX_SPK_CFG2) begin
      class_ab_r <= avs_writedata_i[ASPC_SPK_CLASS];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      guard_a_r <= ASPC_GUARD_RESET;
      guard_b_r <= ASPC_GUARD_RESET;
    end else if (wr && hit && idx == ASPC_IDX_SPK_CFG2) begin
      guard_a_r <= avs_writedata_i[ASPC_SPK_GUARD_A];
      guard_b_r <= avs_writedata_i[ASPC_SPK_GUARD_B];
    end else if (ce_i && class_ab_r == ASPC_CLASS_D && seq_stage_r != 2'd0
                 && seq_cnt_r == 16'h0000) begin
      // A switch to Class AB mid sequence hands the guards back to the host alone.
      if ((seq_stage_r == 2'd1) == seq_target_r) begin
        guard_a_r <= ~seq_target_r;
      end else begin
        guard_b_r <= ~seq_target_r;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mixer_o <= '0;
      line_out_o <= {1'b0, ASPC_MUTE_RESET, ASPC_VOL_RESET};
      spk_gain_o <= {1'b0, ASPC_MUTE_RESET, ASPC_VOL_RESET};
      speaker_o <= {2'b00, 1'b0, ASPC_GUARD_RESET, ASPC_GUARD_RESET};
    end else if (ce_i) begin
      mixer_o <= {mixer_r[ASPC_MIX_IN_A_EN], mixer_r[ASPC_MIX_IN_A_ATT],
                  mixer_r[ASPC_MIX_IN_B_EN], mixer_r[ASPC_MIX_IN_B_ATT],
                  mixer_r[ASPC_MIX_CONV_SEL]};
      line_out_o <= {power_r[2], line_reg_r[ASPC_LVL_MUTE], line_vol_r};
      spk_gain_o <= {power_r[1], spk_reg_r[ASPC_LVL_MUTE], spk_vol_r};
      speaker_o <= {power_r[1], power_r[0], class_ab_r, guard_a_r, guard_b_r};
    end
  end
endmodule
`default_nettype wire

// ==== testbench/aspc_top_props.sv ====
/* Concurrent checks on the signal path control ports.
   Assumes it is bound to aspc_top and that bus requests come one at a time. */
`timescale 1ns/1ps
`default_nettype none
module aspc_top_props import aspc_pkg::*; #(
  parameter int GUARD_STEP = 4
) (
  input wire logic clock_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic ce_i, // Enable.
  input wire logic [5:0] avs_address_i, // Address.
  input wire logic avs_read_i, // Read.
  input wire logic avs_write_i, // Write.
  input wire logic [31:0] avs_writedata_i, // Write data.
  input wire logic [3:0] avs_byteenable_i, // Lanes.
  input wire logic [31:0] avs_readdata_o, // Read data.
  input wire logic avs_waitrequest_o, // Stall.
  input wire logic line_zero_cross_i, // Line crossing.
  input wire logic spk_zero_cross_i, // Speaker crossing.
  input wire aspc_mixer_t mixer_o, // Mixer.
  input wire aspc_level_t line_out_o, // Line level.
  input wire aspc_level_t spk_gain_o, // Speaker level.
  input wire aspc_speaker_t speaker_o // Speaker.
);
  localparam int SEQ_MAX = 2 * GUARD_STEP + 8;
  logic wr_t;
  logic rd_t;
  logic [4:0] mix_bits;
  logic [31:0] wd;
  assign wr_t = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_t = avs_read_i && !avs_waitrequest_o;
  assign wd = avs_writedata_i;
  assign mix_bits = {mixer_o.conv_enable, mixer_o.in_b_atten, mixer_o.in_b_enable,
                     mixer_o.in_a_atten, mixer_o.in_a_enable};
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_rst;
    $fell(rst_i) |-> mixer_o == 5'h00 && line_out_o == 8'h79 && spk_gain_o == 8'h79
      && speaker_o == 5'h03;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  property p_mix;
    wr_t && avs_address_i == 6'h07 |-> ##2 mix_bits == $past(wd[4:0], 2);
  endproperty
  a_mix: assert property (p_mix) else $error("mixer controls wrong");
  property p_rd_mix;
    rd_t && avs_address_i == 6'h07 |-> avs_readdata_o == {27'h0, mix_bits};
  endproperty
  a_rd_mix: assert property (p_rd_mix) else $error("mixer readback wrong");
  property p_pwr;
    wr_t && avs_address_i == 6'h0b |-> ##2 line_out_o.enable == $past(wd[4], 2)
      && speaker_o.gain_stage_enable == $past(wd[2], 2)
      && speaker_o.driver_enable == $past(wd[1], 2);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power enables wrong");
  property p_mute;
    wr_t && avs_address_i == 6'h02 |-> ##2 line_out_o.mute == $past(wd[7], 2);
  endproperty
  a_mute: assert property (p_mute) else $error("line mute wrong");
  property p_vol;
    wr_t && avs_address_i == 6'h02 && !wd[6] |-> ##2 line_out_o.volume == $past(wd[5:0], 2);
  endproperty
  a_vol: assert property (p_vol) else $error("line volume not immediate");
  property p_spk;
    wr_t && avs_address_i == 6'h03 && !wd[6]
      |-> ##2 {spk_gain_o.mute, spk_gain_o.volume} == $past({wd[7], wd[5:0]}, 2);
  endproperty
  a_spk: assert property (p_spk) else $error("speaker level wrong");
  property p_seq;
    wr_t && avs_address_i == 6'h0b && wd[1] && !speaker_o.class_ab
      |-> ##[1:SEQ_MAX] !speaker_o.pop_guard_a && !speaker_o.pop_guard_b;
  endproperty
  a_seq: assert property (p_seq) else $error("guards not released");
  property p_ab;
    speaker_o.class_ab && $past(speaker_o.class_ab)
      && $changed({speaker_o.pop_guard_a, speaker_o.pop_guard_b})
      |-> $past(wr_t && avs_address_i == 6'h0a, 2);
  endproperty
  a_ab: assert property (p_ab) else $error("guards moved without host");
endmodule
`default_nettype wire

// ==== testbench/aspc_host_model.sv ====
/* Host side model: an Avalon-MM master that performs single register transfers.
   Assumes the slave answers through waitrequest on clock_i. */
`timescale 1ns/1ps
`default_nettype none
module aspc_host_model (
  input wire logic clock_i, // Bus clock.
  input wire logic waitrequest_i, // Slave stall.
  input wire logic [31:0] readdata_i, // Read data.
  output logic [5:0] address_o, // Word address.
  output logic read_o, // Read request.
  output logic write_o, // Write request.
  output logic [31:0] writedata_o, // Write data.
  output logic [3:0] byteenable_o, // Lanes.
  output logic [7:0] misses_o // Transfers that never ended.
);
  initial begin
    address_o = 6'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'h0;
    misses_o = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    address_o <= a;
    writedata_o <= d;
    write_o <= wr;
    read_o <= !wr;
    byteenable_o <= 4'h1;
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0 && n < 64) begin
      @(posedge clock_i);
      n++;
    end
    q = readdata_i;
    if (n == 64) misses_o <= misses_o + 8'h01;
    write_o <= 1'b0;
    read_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/aspc_top_test.sv ====
/* Self-checking bench for the signal path control block.
   Assumes the checker and the host model files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module aspc_top_test;
  import aspc_pkg::*;
  localparam int GS = 4;
  logic clock_i, rst_i, ce_i, lzc, szc, rd, wr, wt;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  logic [7:0] misses;
  aspc_mixer_t mix;
  aspc_level_t lo, sg;
  aspc_speaker_t spk;
  int bad_count, cmp_count, cyc;
  aspc_top #(.GUARD_STEP(GS)) DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .line_zero_cross_i(lzc), .spk_zero_cross_i(szc), .mixer_o(mix), .line_out_o(lo),
    .spk_gain_o(sg), .speaker_o(spk));
  aspc_host_model host (.clock_i(clock_i), .waitrequest_i(wt), .readdata_i(rdat),
    .address_o(adr), .read_o(rd), .write_o(wr), .writedata_o(wd), .byteenable_o(be),
    .misses_o(misses));
  always #2.5 clock_i = ~clock_i;
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task print_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wrs(input logic [5:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
    repeat (2) @(posedge clock_i);
  endtask
  task rdc(input logic [5:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk("readback", q, e);
  endtask
  // Waits for two guard changes and checks the state after each.
  task guard_seq(input logic [1:0] mid, input logic [1:0] fin);
    logic [1:0] s;
    int n;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      s = {spk.pop_guard_a, spk.pop_guard_b};
      while ({spk.pop_guard_a, spk.pop_guard_b} === s && n < 60) begin
        @(posedge clock_i);
        n++;
      end
      chk("guards", {spk.pop_guard_a, spk.pop_guard_b}, k == 0 ? mid : fin);
    end
  endtask
  task t_reset;
    logic [5:0] a [6] = '{6'h02, 6'h03, 6'h07, 6'h0a, 6'h0b, 6'h00};
    logic [31:0] e [6] = '{32'hb9, 32'hb9, 32'h0, 32'h18, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) rdc(a[i], e[i]);
  endtask
  task t_mixer;
    logic [4:0] p [3] = '{5'h15, 5'h0a, 5'h1f};
    for (int i = 0; i < 3; i++) begin
      wrs(6'h07, 32'hffffffe0 | p[i]);
      chk("mixer", mix, {p[i][0], p[i][1], p[i][2], p[i][3], p[i][4]});
      rdc(6'h07, {27'h0, p[i]});
    end
  endtask
  task t_levels;
    wrs(6'h02, 32'h3f);
    chk("line", lo, 8'h3f);
    wrs(6'h02, 32'h80);
    chk("line", lo, 8'h40);
    wrs(6'h03, 32'h00);
    chk("spk_gain", sg, 8'h00);
  endtask
  task t_power;
    wrs(6'h0b, 32'h14);
    chk("line_en", lo.enable, 1'b1);
    repeat (3 * GS) @(posedge clock_i);
    wrs(6'h0b, 32'h16);
    guard_seq(2'b01, 2'b00);
    wrs(6'h0b, 32'h14);
    guard_seq(2'b01, 2'b11);
    wrs(6'h0b, 32'h10);
    chk("spk_en", {spk.gain_stage_enable, spk.driver_enable}, 2'b00);
  endtask
  task t_class_ab;
    wrs(6'h0a, 32'h40);
    chk("spk", spk, 5'h04);
    wrs(6'h0b, 32'h16);
    repeat (3 * GS + 4) @(posedge clock_i);
    chk("spk", spk, 5'h1c);
    wrs(6'h0b, 32'h14);
    wrs(6'h0b, 32'h10);
    wrs(6'h0a, 32'h18);
    chk("spk", spk, 5'h03);
  endtask
  task t_zc;
    wrs(6'h0c, 32'h0);
    wrs(6'h02, 32'h4a);
    repeat (5) @(posedge clock_i);
    chk("line", lo, 8'h80);
    rdc(6'h02, 32'h4a);
    wrs(6'h02, 32'h55);
    lzc <= 1'b1;
    @(posedge clock_i);
    lzc <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("line_vol", lo.volume, 6'h15);
    wrs(6'h03, 32'h62);
    repeat (20) @(posedge clock_i);
    chk("spk_vol", sg.volume, 6'h00);
    wrs(6'h0c, 32'h103);
    repeat (12) @(posedge clock_i);
    chk("spk_vol", sg.volume, 6'h22);
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    lzc = 1'b0;
    szc = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_mixer();
    t_levels();
    t_power();
    t_class_ab();
    t_zc();
    chk("bus_misses", misses, 8'h00);
    print_verdict();
  end
endmodule
bind aspc_top aspc_top_props #(.GUARD_STEP(GUARD_STEP)) u_props (.clock_i(clock_i),
  .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .line_zero_cross_i(line_zero_cross_i),
  .spk_zero_cross_i(spk_zero_cross_i), .mixer_o(mixer_o), .line_out_o(line_out_o),
  .spk_gain_o(spk_gain_o), .speaker_o(speaker_o));
`default_nettype wire
